/* hw/fcr_bank.sv */
// Purpose: AXI4-Lite register bank of an on-chip flash programming controller.
// Assumes: Engine reports completion and errors as one-cycle event pulses.
// Notes:   Clear, set and invert aliases sit at +0x4, +0x8 and +0xC.
`default_nettype none
// Summary of operation
// - Unlock key reads always return zero.
// - Clear/set/invert aliases at +4, +8, +C.
// - Unimplemented bits read back as zero.
// - Control: start, enable, error, low-voltage error.
// - Page protect resets with unlock bit set.
// - Unlock key is write-only, resets zero.
// - Target address fully read/write, resets zero.
// - Ignore address low bits per operation.
module fcr_bank
  import fcr_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [13:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [13:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output fcr_cmd_t         CMD,
  input  wire fcr_evt_t    EVT,
  output logic [31:0]      KEY_VALUE,
  output logic             KEY_WRITE,
  output logic [63:0]      PROGRAM_DATA,
  output logic [31:0]      ROW_SOURCE,
  output logic [31:0]      PAGE_PROTECT,
  output logic [31:0]      BOOT_PROTECT,
  output logic             IRQ
);
  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Address and data are latched independently so either order works.
  logic        aw_have_r;
  logic [13:0] aw_addr_r;
  logic        w_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic        bresp_err_r;

  wire         aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire         w_take  = S_AXI_WVALID & S_AXI_WREADY;
  wire         do_wr   = aw_have_r & w_have_r & ~bvalid_r;

  assign S_AXI_AWREADY = ~aw_have_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_have_r & ~bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_err_r ? FCR_RESP_SLVERR : FCR_RESP_OKAY;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 14'h0000;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (do_wr) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire [13:0] wr_slot  = {aw_addr_r[13:4], 4'h0};
  wire [1:0]  wr_alias = aw_addr_r[3:2];
  wire        wr_plain = (wr_alias == FCR_ALIAS_PLAIN);
  wire [31:0] wmask    = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                          {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] wbits    = w_data_r & wmask;

  wire hit_ctl  = (wr_slot == FCR_OFF_CONTROL);
  wire hit_key  = (wr_slot == FCR_OFF_KEY) && wr_plain;
  wire hit_addr = (wr_slot == FCR_OFF_ADDR);
  wire hit_dlo  = (wr_slot == FCR_OFF_DATA_LO) && wr_plain;
  wire hit_dhi  = (wr_slot == FCR_OFF_DATA_HI) && wr_plain;
  wire hit_src  = (wr_slot == FCR_OFF_SRC) && wr_plain;
  wire hit_pprot = (wr_slot == FCR_OFF_PPROT);
  wire hit_bprot = (wr_slot == FCR_OFF_BPROT);
  wire hit_ist  = (wr_slot == FCR_OFF_IRQ_STAT) && wr_plain;
  wire hit_imk  = (wr_slot == FCR_OFF_IRQ_MASK) && wr_plain;
  wire wr_ok    = hit_ctl | hit_key | hit_addr | hit_dlo | hit_dhi | hit_src |
                  hit_pprot | hit_bprot | hit_ist | hit_imk;

  // Applies a plain write or one of the clear, set and invert aliases.
  function automatic logic [31:0] fcr_alias(input logic [31:0] cur,
                                            input logic [31:0] bits,
                                            input logic [31:0] keep,
                                            input logic [1:0]  kind);
    logic [31:0] res;
    res = cur;
    case (kind)
      FCR_ALIAS_CLR: res = cur & ~bits;
      FCR_ALIAS_SET: res = cur | bits;
      FCR_ALIAS_INV: res = cur ^ bits;
      default:       res = (cur & ~keep) | (bits & keep);
    endcase
    return res;
  endfunction : fcr_alias

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctl_r, ctl_nxt;
  logic [31:0] key_r;
  logic [31:0] addr_r;
  logic [31:0] dlo_r;
  logic [31:0] dhi_r;
  logic [31:0] src_r;
  logic [31:0] pprot_r, pprot_nxt;
  logic [31:0] bprot_r, bprot_nxt;
  logic [31:0] ist_r, ist_nxt;
  logic [31:0] imk_r;
  logic        key_wr_r;

  always_comb begin
    ctl_nxt = hit_ctl && do_wr ?
              fcr_alias(ctl_r, wbits, wmask, wr_alias) & FCR_CTL_MASK : ctl_r;
    // The engine ends a cycle by dropping start; errors set and win.
    if (EVT.done) ctl_nxt[FCR_CTL_START] = 1'b0;
    if (EVT.prog_err) ctl_nxt[FCR_CTL_PERR] = 1'b1;
    if (EVT.lv_err) ctl_nxt[FCR_CTL_LVERR] = 1'b1;
    pprot_nxt = hit_pprot && do_wr ?
              fcr_alias(pprot_r, wbits, wmask, wr_alias) & FCR_PPROT_MASK : pprot_r;
    bprot_nxt = hit_bprot && do_wr ?
              fcr_alias(bprot_r, wbits, wmask, wr_alias) & FCR_BPROT_MASK : bprot_r;
    // Write-one-to-clear; a new event in the same cycle stays set.
    ist_nxt = hit_ist && do_wr ? ist_r & ~wbits : ist_r;
    ist_nxt = (ist_nxt | {29'h0, EVT}) & FCR_IRQ_MASKBITS;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_r    <= FCR_RST_CONTROL;
      key_r    <= FCR_RST_ZERO;
      addr_r   <= FCR_RST_ZERO;
      dlo_r    <= FCR_RST_ZERO;
      dhi_r    <= FCR_RST_ZERO;
      src_r    <= FCR_RST_ZERO;
      pprot_r  <= FCR_RST_PPROT;
      bprot_r  <= FCR_RST_BPROT;
      ist_r    <= FCR_RST_ZERO;
      imk_r    <= FCR_RST_ZERO;
      key_wr_r <= 1'b0;
    end else begin
      ctl_r    <= ctl_nxt;
      pprot_r  <= pprot_nxt;
      bprot_r  <= bprot_nxt;
      ist_r    <= ist_nxt;
      key_wr_r <= hit_key & do_wr;
      if (hit_key && do_wr) key_r <= wbits;
      if (hit_addr && do_wr) addr_r <= fcr_alias(addr_r, wbits, wmask, wr_alias);
      if (hit_dlo && do_wr) dlo_r <= (dlo_r & ~wmask) | wbits;
      if (hit_dhi && do_wr) dhi_r <= (dhi_r & ~wmask) | wbits;
      if (hit_src && do_wr) src_r <= (src_r & ~wmask) | wbits;
      if (hit_imk && do_wr) imk_r <= wbits & FCR_IRQ_MASKBITS;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_r    <= 1'b0;
      bresp_err_r <= 1'b0;
    end else if (do_wr) begin
      bvalid_r    <= 1'b1;
      bresp_err_r <= ~wr_ok;
    end else if (S_AXI_BREADY) begin
      bvalid_r    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic        rresp_err_r;
  logic [31:0] rd_val;
  logic        rd_ok;
  wire  [13:0] rd_slot = {S_AXI_ARADDR[13:4], 4'h0};
  wire         rd_take = S_AXI_ARVALID & S_AXI_ARREADY;

  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_err_r ? FCR_RESP_SLVERR : FCR_RESP_OKAY;

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    if (rd_slot == FCR_OFF_CONTROL) rd_val = ctl_r & FCR_CTL_MASK;
    else if (rd_slot == FCR_OFF_KEY) rd_val = 32'h00000000;
    else if (rd_slot == FCR_OFF_ADDR) rd_val = addr_r;
    else if (rd_slot == FCR_OFF_DATA_LO) rd_val = dlo_r;
    else if (rd_slot == FCR_OFF_DATA_HI) rd_val = dhi_r;
    else if (rd_slot == FCR_OFF_SRC) rd_val = src_r;
    else if (rd_slot == FCR_OFF_PPROT) rd_val = pprot_r & FCR_PPROT_MASK;
    else if (rd_slot == FCR_OFF_BPROT) rd_val = bprot_r & FCR_BPROT_MASK;
    else if (rd_slot == FCR_OFF_IRQ_STAT) rd_val = ist_r;
    else if (rd_slot == FCR_OFF_IRQ_MASK) rd_val = imk_r;
    else rd_ok = 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h00000000;
      rresp_err_r <= 1'b0;
    end else if (rd_take) begin
      rvalid_r    <= 1'b1;
      rdata_r     <= rd_val;
      rresp_err_r <= ~rd_ok;
    end else if (S_AXI_RREADY) begin
      rvalid_r    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Engine side outputs
  // ----------------------------------------------------------------
  // Low address bits are dropped here for page, row and dword operations; other op codes pass addr_r whole.
  logic [31:0] eff_addr;
  always_comb begin
    eff_addr = addr_r;
    case (ctl_r[FCR_CTL_OPSEL +: 4])
      FCR_OP_PAGE:  eff_addr = {addr_r[31:11], 11'h000};
      FCR_OP_ROW:   eff_addr = {addr_r[31:8], 8'h00};
      FCR_OP_DWORD: eff_addr = {addr_r[31:2], 2'h0};
      default:      eff_addr = addr_r;
    endcase
  end

  assign CMD.start     = ctl_r[FCR_CTL_START];
  assign CMD.enable    = ctl_r[FCR_CTL_ENABLE];
  assign CMD.op        = ctl_r[FCR_CTL_OPSEL +: 4];
  assign CMD.addr      = eff_addr;
  assign KEY_VALUE     = key_r;
  assign KEY_WRITE     = key_wr_r;
  assign PROGRAM_DATA  = {dhi_r, dlo_r};
  assign ROW_SOURCE    = src_r;
  assign PAGE_PROTECT  = pprot_r;
  assign BOOT_PROTECT  = bprot_r;
  // Level output; it falls only when software clears or masks the cause.
  assign IRQ           = |(ist_r & imk_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_key_read;
    rd_take && (rd_slot == FCR_OFF_KEY);
  endsequence

  a_key_reads_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    s_key_read |=> (S_AXI_RDATA == 32'h00000000))
    else $error("Unlock key read returned nonzero data.");

  a_ctl_set_alias: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_wr && hit_ctl && wr_alias == FCR_ALIAS_SET && !EVT.done)
    |=> ((ctl_r & $past(wbits) & FCR_CTL_MASK) == ($past(wbits) & FCR_CTL_MASK)))
    else $error("Control set alias failed to set bits.");

  a_pprot_clr_alias: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_wr && hit_pprot && wr_alias == FCR_ALIAS_CLR)
    |=> ((pprot_r & $past(wbits)) == 32'h00000000))
    else $error("Page protect clear alias left bits set.");

  a_bprot_inv_alias: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_wr && hit_bprot && wr_alias == FCR_ALIAS_INV)
    |=> (bprot_r == (($past(bprot_r) ^ $past(wbits)) & FCR_BPROT_MASK)))
    else $error("Boot protect invert alias wrong.");

  a_unimpl_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    ((ctl_r & ~FCR_CTL_MASK) == 32'h0) && ((pprot_r & ~FCR_PPROT_MASK) == 32'h0)
    && ((bprot_r & ~FCR_BPROT_MASK) == 32'h0))
    else $error("Unimplemented bit became set.");

  a_perr_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    EVT.prog_err |=> ctl_r[FCR_CTL_PERR] && ist_r[1])
    else $error("Program error event not recorded.");

  a_addr_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_wr && hit_addr && wr_plain && w_strb_r == 4'hF) |=> addr_r == $past(w_data_r))
    else $error("Target address write not stored.");

  a_page_align: assert property (@(posedge CLK) disable iff (!RST_N)
    (CMD.op == FCR_OP_PAGE) |-> (CMD.addr[10:0] == 11'h000))
    else $error("Page erase address low bits not ignored.");

  a_key_write_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    KEY_WRITE |-> ##1 !KEY_WRITE || $past(do_wr))
    else $error("Key write strobe stuck.");

  sequence s_bad_write;
    do_wr && !wr_ok;
  endsequence

  a_bad_alias_err: assert property (@(posedge CLK) disable iff (!RST_N)
    s_bad_write |=> (S_AXI_BVALID && S_AXI_BRESP == FCR_RESP_SLVERR))
    else $error("Write to a slot without that alias was not refused.");

  a_addr_inv_alias: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_wr && hit_addr && wr_alias == FCR_ALIAS_INV)
    |=> (addr_r == ($past(addr_r) ^ $past(wbits))))
    else $error("Target address invert alias wrong.");

  a_unmapped_read: assert property (@(posedge CLK) disable iff (!RST_N)
    (rd_take && !rd_ok) |=> (S_AXI_RDATA == 32'h00000000))
    else $error("Unmapped read returned nonzero data.");

  a_done_clears_start: assert property (@(posedge CLK) disable iff (!RST_N)
    EVT.done |=> !CMD.start)
    else $error("Start bit survived a done event.");

  a_key_write_stored: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_wr && hit_key) |=> (KEY_WRITE && KEY_VALUE == $past(wbits)))
    else $error("Unlock key write not stored or not strobed.");
endmodule : fcr_bank
`default_nettype wire

/* inc/fcr_pkg.sv */
// Purpose: Constants and types for the flash control register bank.
// Assumes: AXI4-Lite slave with 32-bit data and word-aligned registers.
// Notes:   Offsets are byte addresses within the bank window.
`default_nettype none
package fcr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [13:0] FCR_OFF_CONTROL  = 14'h2380;
  localparam logic [13:0] FCR_OFF_KEY      = 14'h2390;
  localparam logic [13:0] FCR_OFF_ADDR     = 14'h23A0;
  localparam logic [13:0] FCR_OFF_DATA_LO  = 14'h23B0;
  localparam logic [13:0] FCR_OFF_DATA_HI  = 14'h23C0;
  localparam logic [13:0] FCR_OFF_SRC      = 14'h23D0;
  localparam logic [13:0] FCR_OFF_PPROT    = 14'h23E0;
  localparam logic [13:0] FCR_OFF_BPROT    = 14'h23F0;
  localparam logic [13:0] FCR_OFF_IRQ_STAT = 14'h2400;
  localparam logic [13:0] FCR_OFF_IRQ_MASK = 14'h2410;
  // Alias sub-offsets within each 16-byte register slot.
  localparam logic [1:0]  FCR_ALIAS_PLAIN  = 2'h0;
  localparam logic [1:0]  FCR_ALIAS_CLR    = 2'h1;
  localparam logic [1:0]  FCR_ALIAS_SET    = 2'h2;
  localparam logic [1:0]  FCR_ALIAS_INV    = 2'h3;
  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int          FCR_CTL_START    = 15;
  localparam int          FCR_CTL_ENABLE   = 14;
  localparam int          FCR_CTL_PERR     = 13;
  localparam int          FCR_CTL_LVERR    = 12;
  localparam int          FCR_CTL_OPSEL    = 0;
  localparam logic [31:0] FCR_CTL_MASK     = 32'h0000F00F;
  localparam logic [31:0] FCR_PPROT_MASK   = 32'h80FFFFFF;
  localparam logic [31:0] FCR_BPROT_MASK   = 32'h00008700;
  localparam logic [31:0] FCR_IRQ_MASKBITS = 32'h00000007;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FCR_RST_CONTROL  = 32'h00000000;
  localparam logic [31:0] FCR_RST_ZERO     = 32'h00000000;
  localparam logic [31:0] FCR_RST_PPROT    = 32'h80000000;
  localparam logic [31:0] FCR_RST_BPROT    = 32'h00008700;
  // ----------------------------------------------------------------
  // Operation codes and types
  // ----------------------------------------------------------------
  localparam logic [3:0]  FCR_OP_DWORD     = 4'h2;
  localparam logic [3:0]  FCR_OP_ROW       = 4'h3;
  localparam logic [3:0]  FCR_OP_PAGE      = 4'h4;
  localparam logic [1:0]  FCR_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  FCR_RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic        start;
    logic        enable;
    logic [3:0]  op;
    logic [31:0] addr;
  } fcr_cmd_t;

  typedef struct packed {
    logic done;
    logic prog_err;
    logic lv_err;
  } fcr_evt_t;
endpackage : fcr_pkg
`default_nettype wire

/* verification/fcr_engine_model.sv */
// Purpose: Behavioural flash engine that answers a start command with event pulses.
// Assumes: One operation at a time; FAULT is held steady by the bench during a run.
// Notes:   DELAY sets the length of an operation in clock cycles.
`default_nettype none
module fcr_engine_model
  import fcr_pkg::*;
#(
  parameter int DELAY = 5
)(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire fcr_cmd_t   CMD,
  input  wire logic [1:0] FAULT,
  output var  fcr_evt_t   EVT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run_r;
  logic start_q_r;
  int   cnt_r;
  // Starting on the rising edge of start avoids a second run while start is still high.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_r     <= 1'b0;
      start_q_r <= 1'b0;
      cnt_r     <= 0;
      EVT       <= '0;
    end else begin
      start_q_r <= CMD.start;
      EVT       <= '0;
      if (!run_r && CMD.start && !start_q_r && CMD.enable) begin
        run_r <= 1'b1;
        cnt_r <= DELAY;
      end else if (run_r && cnt_r > 0) begin
        cnt_r <= cnt_r - 1;
      end else if (run_r) begin
        run_r <= 1'b0;
        EVT   <= '{done: 1'b1, prog_err: FAULT[0], lv_err: FAULT[1]};
      end
    end
  end
endmodule : fcr_engine_model
`default_nettype wire

/* verification/flash_ctrl_register_bank_tb.sv */
// Purpose: Self-checking bench of the flash control register bank over AXI4-Lite.
// Assumes: Single clock at 100 MHz; engine modelled by fcr_engine_model.
// Notes:   Control writes keep start low except where a run is meant to begin.
`default_nettype none
module flash_ctrl_register_bank_tb
  import fcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic        CLK, RST_N, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, key_write, irq;
  logic [13:0] awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, fault, rsp, err;
  logic [31:0] wdata, rdata, key_value, row_src, pprot_out, bprot_out, rdat, d;
  logic [63:0] prog_data;
  fcr_cmd_t    cmd;
  fcr_evt_t    evt;
  int          fail_count, n_checks, key_pulses, i, j, k, n;
  logic [31:0] mdl [10];
  localparam logic [13:0] OFFS [10] = '{FCR_OFF_CONTROL, FCR_OFF_KEY, FCR_OFF_ADDR,
    FCR_OFF_DATA_LO, FCR_OFF_DATA_HI, FCR_OFF_SRC, FCR_OFF_PPROT, FCR_OFF_BPROT,
    FCR_OFF_IRQ_STAT, FCR_OFF_IRQ_MASK};
  localparam logic [31:0] RSTV [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h80000000, 32'h00008700, 32'h0, 32'h0};
  localparam logic [31:0] MSK [10] = '{32'h0000400F, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'hFFFFFFFF, FCR_PPROT_MASK, FCR_BPROT_MASK, 32'h0, 32'h7};
  localparam int AL [4] = '{0, 2, 6, 7};
  localparam logic [3:0] OPS [4] = '{FCR_OP_DWORD, FCR_OP_ROW, FCR_OP_PAGE, 4'h0};

  fcr_bank uut (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CMD(cmd),
    .EVT(evt), .KEY_VALUE(key_value), .KEY_WRITE(key_write), .PROGRAM_DATA(prog_data),
    .ROW_SOURCE(row_src), .PAGE_PROTECT(pprot_out), .BOOT_PROTECT(bprot_out), .IRQ(irq));
  fcr_engine_model #(.DELAY(5)) eng (.CLK(CLK), .RST_N(RST_N), .CMD(cmd), .FAULT(fault),
    .EVT(evt));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) if (key_write === 1'b1) key_pulses++;
  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("Checks: %0d, mismatches: %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, where nothing changes before the next rise.
  task automatic wr(input logic [13:0] a, input logic [31:0] v);
    logic aw_hs, w_hs, b_hs;
    int   t;
    b_hs = 1'b0;
    @(posedge CLK);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (t = 0; t < 200 && !b_hs; t++) begin
      @(negedge CLK);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid;
      rsp   = bresp;
      @(posedge CLK);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("write_answer", 1'b1, b_hs);
  endtask : wr

  task automatic rd(input logic [13:0] a);
    logic ar_hs, r_hs;
    int   t;
    r_hs = 1'b0;
    @(posedge CLK);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (t = 0; t < 200 && !r_hs; t++) begin
      @(negedge CLK);
      ar_hs = arvalid && arready;
      r_hs  = rvalid;
      rdat  = rdata;
      rsp   = rresp;
      @(posedge CLK);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("read_answer", 1'b1, r_hs);
  endtask : rd

  function automatic logic [31:0] exp_alias(input logic [31:0] o, input logic [31:0] v,
                                            input int kind);
    case (kind)
      1: return o & ~v;
      2: return o | v;
      3: return o ^ v;
      default: return v;
    endcase
  endfunction : exp_alias

  function automatic logic [31:0] exp_addr(input logic [3:0] op);
    case (op)
      FCR_OP_DWORD: return 32'hFFFFFFFC;
      FCR_OP_ROW: return 32'hFFFFFF00;
      FCR_OP_PAGE: return 32'hFFFFF800;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction : exp_addr
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, RST_N} = '0;
    {awaddr, araddr, wdata, fault} = '0;
    wstrb = 4'hF;
    {fail_count, n_checks, key_pulses} = '0;
    void'($urandom(32'hA70A));
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    chk("pprot_out_reset", 32'h80000000, pprot_out);
    chk("bprot_out_reset", 32'h00008700, bprot_out);
    for (i = 0; i < 10; i++) begin
      mdl[i] = RSTV[i];
      rd(OFFS[i]);
      chk("reset_value", RSTV[i], rdat);
    end
    for (j = 0; j < 2; j++) for (i = 0; i < 10; i++) if (i != 1 && i != 8) begin
      d = (j == 0) ? 32'hFFFFFFFF : $urandom;
      if (i == 0) d = d & 32'h0000400F;
      wr(OFFS[i], d);
      mdl[i] = d & MSK[i];
      rd(OFFS[i]);
      chk("plain_rw", mdl[i], rdat);
    end
    chk("program_data", {mdl[4], mdl[3]}, prog_data);
    chk("row_source", mdl[5], row_src);
    chk("pprot_out", mdl[6], pprot_out);
    chk("bprot_out", mdl[7], bprot_out);
    // Only the two low byte lanes are enabled, so the upper half must survive.
    wstrb <= 4'h3;
    wr(FCR_OFF_SRC, 32'hFFFFFFFF);
    wstrb <= 4'hF;
    mdl[5][15:0] = 16'hFFFF;
    rd(FCR_OFF_SRC);
    chk("strobe_mask", mdl[5], rdat);
    for (j = 0; j < 24; j++) begin
      i = AL[j % 4];
      k = 1 + (j / 4) % 3;
      d = $urandom & ((i == 0) ? 32'h0000400F : 32'hFFFFFFFF);
      wr(OFFS[i] + 14'(4 * k), d);
      chk("alias_resp", FCR_RESP_OKAY, rsp);
      mdl[i] = exp_alias(mdl[i], d, k) & MSK[i];
      rd(OFFS[i] + 14'(4 * k));
      chk("alias_value", mdl[i], rdat);
    end
    wr(FCR_OFF_ADDR, 32'hFFFFFFFF);
    for (j = 0; j < 4; j++) begin
      wr(FCR_OFF_CONTROL, 32'h00004000 | OPS[j]);
      @(negedge CLK);
      chk("cmd_addr", exp_addr(OPS[j]), cmd.addr);
      chk("cmd_enable_op", {1'b1, OPS[j]}, {cmd.enable, cmd.op});
    end
    err = 2'b00;
    wr(FCR_OFF_IRQ_MASK, 32'h0);
    for (j = 0; j < 4; j++) begin
      fault <= j[1:0];
      err = err | j[1:0];
      wr(FCR_OFF_CONTROL + 14'h8, 32'h00008000);
      for (n = 0; n < 50 && cmd.start !== 1'b0; n++) @(negedge CLK);
      chk("start_cleared", 1'b0, cmd.start);
      rd(FCR_OFF_CONTROL);
      chk("control_errors", 32'h00004000 | {err[0], err[1], 12'h000}, rdat);
      rd(FCR_OFF_IRQ_STAT);
      chk("irq_status", {1'b1, j[0], j[1]}, rdat);
      chk("irq_masked", 1'b0, irq);
      wr(FCR_OFF_IRQ_MASK, 32'h7);
      @(negedge CLK);
      chk("irq_raised", 1'b1, irq);
      wr(FCR_OFF_IRQ_STAT, 32'h7);
      @(negedge CLK);
      chk("irq_cleared", 1'b0, irq);
      wr(FCR_OFF_IRQ_MASK, 32'h0);
    end
    d = $urandom;
    key_pulses = 0;
    wr(FCR_OFF_KEY, d);
    repeat (2) @(posedge CLK);
    chk("key_value", d, key_value);
    chk("key_pulses", 1, key_pulses);
    rd(FCR_OFF_KEY);
    chk("key_read", 32'h0, rdat);
    rd(14'h3000);
    chk("unmapped", {FCR_RESP_SLVERR, 32'h0}, {rsp, rdat});
    wr(FCR_OFF_DATA_LO + 14'h8, 32'hFFFFFFFF);
    chk("bad_alias_resp", FCR_RESP_SLVERR, rsp);
    rd(FCR_OFF_DATA_LO);
    chk("bad_alias_kept", mdl[3], rdat);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(FCR_OFF_PPROT);
    chk("pprot_rereset", 32'h80000000, rdat);
    rd(FCR_OFF_ADDR);
    chk("addr_rereset", 32'h0, rdat);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    give_verdict();
  end
endmodule : flash_ctrl_register_bank_tb
`default_nettype wire
